//--- asu_defs.vh
// Register offsets, field positions, reset values and timing constants
`ifndef ASU_DEFS_VH
`define ASU_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets (8-bit register port)
// ----------------------------------------------------------------------------
`define ASU_ADDR_W        3
`define ASU_OFF_TXSHIFT   3'h0
`define ASU_OFF_RXBUF     3'h0
`define ASU_OFF_MODE      3'h1
`define ASU_OFF_ERRSTAT   3'h2
`define ASU_OFF_BAUD      3'h3
`define ASU_OFF_PINSEL    3'h4
`define ASU_OFF_FLAGS     3'h5

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define ASU_MODE_TXEN     7
`define ASU_MODE_RXEN     6
`define ASU_MODE_PAR_HI   5
`define ASU_MODE_PAR_LO   4
`define ASU_MODE_CHAR8    3
`define ASU_MODE_STOP2    2
`define ASU_MODE_ERRIRQ   1
`define ASU_MODE_EXTCLK   0
`define ASU_PAR_NONE      2'h0
`define ASU_PAR_ZERO      2'h1
`define ASU_PAR_ODD       2'h2
`define ASU_PAR_EVEN      2'h3

// ----------------------------------------------------------------------------
// Error status, pin select and flag register fields
// ----------------------------------------------------------------------------
`define ASU_ERR_PARITY    2
`define ASU_ERR_FRAMING   1
`define ASU_ERR_OVERRUN   0
`define ASU_PINSEL_OUT    5
`define ASU_PINSEL_IN     4
`define ASU_FLAG_TXDONE   0
`define ASU_FLAG_TXBUSY   1
`define ASU_FLAG_RXBUSY   2

// ----------------------------------------------------------------------------
// Reset values and baud generator constants
// ----------------------------------------------------------------------------
`define ASU_RST_MODE      8'h00
`define ASU_RST_BAUD      8'h00
`define ASU_RST_PINSEL    8'h00
`define ASU_BAUD_K_BASE   5'h10
`define ASU_BAUD_K_MAX    4'hE
`define ASU_PRESC_N_MIN   4'h1
`define ASU_PRESC_N_MAX   4'hB

`endif

//--- asu_uart_channel.v
// Asynchronous serial transmitter and receiver channel with register port
`timescale 1ns/1ps
// Notes on behaviour
// - Frame: start, 7 or 8 data bits, optional parity, 1 or 2 stops.
// - 7-bit mode: transmit ignores data bit 7, receive bit 7 reads zero.
// - Even parity transmit: parity one when data holds odd count of ones.
// - Even parity receive: odd total ones including parity is error.
// - Odd parity: transmit makes total odd, receive flags even total.
// - Zero parity: send zero parity bit, never check on receive.
// - No parity: no parity bit sent or expected, no parity error.
// - Writing transmit shift register starts a framed transmission.
// - Shifter empty raises tx-complete request and sets its flag.
// - Receive enable starts sampling selected input with chosen clock.
// - Low input starts counter; resample at half bit confirms start.
// - After data, parity, one stop: load buffer, raise rx-complete.
// - Errored frame still loads buffer; rx-complete only if mode bit 1 zero.
// - Clearing receive enable stops reception, no buffer or flag change.
// - Disable near frame end: old data, new data, or new data plus irq.
// - Each error sets status flag and rx-error irq at frame end, even when mode bit 1 suppresses rx-complete.
// - Framing error on missing stop; overrun if buffer unread at completion.
// - Error status clears on buffer read or next frame, new errors set.
// - Output select acts only with transmit on, input only with receive on.
// - Internal clock: rate is fclk over two-power-n times (k plus 16).
// - External clock: rate is pin clock over two times (k plus 16).
`include "asu_defs.vh"

module asu_uart_channel (
  input  wire       clk,
  input  wire       nrst,
  input  wire [2:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrStb,
  input  wire       regRdStb,
  output reg  [7:0] regRdData,
  input  wire       serialInPrimary,
  input  wire       serialInAlternate,
  input  wire       externalBaudClockPin,
  output reg        serialOutPrimary,
  output reg        serialOutAlternate,
  output wire       txCompleteIrq,
  output wire       rxCompleteIrq,
  output wire       rxErrorIrq
);

  // --------------------------------------------------------------------------
  // Registers and pin synchronisers
  // --------------------------------------------------------------------------
  reg  [7:0] mode_reg;
  reg  [7:0] baud_reg;
  reg  [7:0] pinSel_reg;
  reg  [7:0] rxBuf_reg;
  reg  [2:0] errStat_reg;
  reg        txDoneFlag_reg;
  reg        rxUnread_reg;
  reg  [1:0] rxPriSync_reg;
  reg  [1:0] rxAltSync_reg;
  reg  [1:0] extClkSync_reg;
  reg        extClkOld_reg;

  wire       txEn    = mode_reg[`ASU_MODE_TXEN];
  wire       rxEn    = mode_reg[`ASU_MODE_RXEN];
  wire [1:0] parMode = mode_reg[`ASU_MODE_PAR_HI:`ASU_MODE_PAR_LO];
  wire       char8   = mode_reg[`ASU_MODE_CHAR8];
  wire       stop2   = mode_reg[`ASU_MODE_STOP2];
  wire       extClk  = mode_reg[`ASU_MODE_EXTCLK];
  wire       parOn   = (parMode != `ASU_PAR_NONE);

  wire wrTx   = regWrStb && (regAddr == `ASU_OFF_TXSHIFT);
  wire wrMode = regWrStb && (regAddr == `ASU_OFF_MODE);
  wire rdBuf  = regRdStb && (regAddr == `ASU_OFF_RXBUF);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxPriSync_reg  <= 2'h3;
      rxAltSync_reg  <= 2'h3;
      extClkSync_reg <= 2'h0;
      extClkOld_reg  <= 1'b0;
    end else begin
      rxPriSync_reg  <= {rxPriSync_reg[0], serialInPrimary};
      rxAltSync_reg  <= {rxAltSync_reg[0], serialInAlternate};
      extClkSync_reg <= {extClkSync_reg[0], externalBaudClockPin};
      extClkOld_reg  <= extClkSync_reg[1];
    end
  end

  // Input select acts only while reception is enabled
  wire rxLine = (rxEn && pinSel_reg[`ASU_PINSEL_IN]) ?
                rxAltSync_reg[1] : rxPriSync_reg[1];

  // --------------------------------------------------------------------------
  // Baud generator: prescaler then 5-bit divide by k+16, half-bit ticks
  // --------------------------------------------------------------------------
  function [3:0] prescN;
    input [7:0] b;
    begin
      if (b[3:0] == 4'h0)
        prescN = `ASU_PRESC_N_MAX;
      else
        prescN = b[3:0] - 4'h4;
    end
  endfunction

  // Odd count of ones over a data and parity field
  function oddOnes;
    input [8:0] v;
    begin
      oddOnes = ^v;
    end
  endfunction

  reg  [10:0] prescCnt_reg;
  reg  [4:0]  divCnt_reg;
  reg         halfTick_reg;
  wire [3:0]  nVal = prescN(baud_reg);
  wire [3:0]  kVal = baud_reg[7:4];
  // Internal source: n-1 prescaler bits feed the divider, so fclk / 2^(n-1)
  // appears at the half-bit divider input; the half-bit tick doubles it.
  wire [10:0] prescMask = (11'h001 << (nVal - 4'h1)) - 11'h001;
  wire        srcTick   = extClk ? (extClkSync_reg[1] && !extClkOld_reg)
                                 : ((prescCnt_reg & prescMask) == prescMask);
  wire [4:0]  divTop    = `ASU_BAUD_K_BASE + {1'b0, kVal} - 5'h1;

  // One baud generator, restarted by receive start detection
  // A restart mid-transmission shifts the transmit bit phase as well
  reg rxRestart;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescCnt_reg <= 11'h000;
      divCnt_reg   <= 5'h00;
      halfTick_reg <= 1'b0;
    end else begin
      halfTick_reg <= 1'b0;
      prescCnt_reg <= prescCnt_reg + 11'h001;
      if (rxRestart) begin
        divCnt_reg <= 5'h00;
      end else if (srcTick) begin
        if (divCnt_reg >= divTop) begin
          divCnt_reg   <= 5'h00;
          halfTick_reg <= 1'b1;
        end else begin
          divCnt_reg <= divCnt_reg + 5'h01;
        end
      end
    end
  end

  // Transmit needs its own half-tick phase since the receiver may restart
  reg txPhase_reg;

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  reg  [11:0] txShift_reg;
  reg  [3:0]  txLeft_reg;
  reg         txBusy_reg;
  reg         txLive_reg;
  wire [7:0]  txData   = char8 ? regWrData : {1'b0, regWrData[6:0]};
  wire        txOnes   = oddOnes({1'b0, txData});
  wire        txParity = (parMode == `ASU_PAR_EVEN) ? txOnes :
                         (parMode == `ASU_PAR_ODD)  ? ~txOnes :
                         1'b0;
  wire [3:0]  txBits   = 4'h1 + (char8 ? 4'h8 : 4'h7)
                       + {3'h0, parOn} + (stop2 ? 4'h2 : 4'h1);
  wire [11:0] txFrame  = char8 ?
                         (parOn ? {2'h3, txParity, txData, 1'b0}
                                : {3'h7, txData, 1'b0})
                       : (parOn ? {3'h7, txParity, txData[6:0], 1'b0}
                                : {4'hF, txData[6:0], 1'b0});
  // Line stays idle until the first half tick aligns the start bit
  wire        txLine   = (txBusy_reg && txLive_reg) ? txShift_reg[0]
                                                    : 1'b1;
  wire        txDoneIrq = txBusy_reg && txLive_reg && txEn && halfTick_reg
                          && txPhase_reg && (txLeft_reg == 4'h1);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txShift_reg    <= 12'hFFF;
      txLeft_reg     <= 4'h0;
      txBusy_reg     <= 1'b0;
      txPhase_reg    <= 1'b0;
      txLive_reg     <= 1'b0;
      txDoneFlag_reg <= 1'b0;
    end else begin
      if (!txEn) begin
        txBusy_reg <= 1'b0;
      end else if (wrTx && !txBusy_reg) begin
        txShift_reg <= txFrame;
        txLeft_reg  <= txBits;
        txBusy_reg  <= 1'b1;
        txPhase_reg <= 1'b0;
        txLive_reg  <= 1'b0;
      end else if (txBusy_reg && halfTick_reg && !txLive_reg) begin
        txLive_reg <= 1'b1;
      end else if (txBusy_reg && halfTick_reg) begin
        txPhase_reg <= ~txPhase_reg;
        if (txPhase_reg) begin
          txShift_reg <= {1'b1, txShift_reg[11:1]};
          txLeft_reg  <= txLeft_reg - 4'h1;
          if (txLeft_reg == 4'h1)
            txBusy_reg <= 1'b0;
        end
      end
      // Completion wins over a same-cycle clear by write
      if (txDoneIrq)
        txDoneFlag_reg <= 1'b1;
      else if (wrTx)
        txDoneFlag_reg <= 1'b0;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      serialOutPrimary   <= 1'b1;
      serialOutAlternate <= 1'b1;
    end else begin
      // Output select acts only while transmission is enabled
      if (txEn && pinSel_reg[`ASU_PINSEL_OUT]) begin
        serialOutPrimary   <= 1'b1;
        serialOutAlternate <= txLine;
      end else begin
        serialOutPrimary   <= txLine;
        serialOutAlternate <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA  = 2'h2;

  reg [1:0] rxState_reg;
  reg [1:0] rxState_next;
  reg [3:0] rxCnt_reg;
  reg       rxPhase_reg;
  reg [8:0] rxShift_reg;
  reg       rxDoneIrq;
  reg       rxErrIrq;
  wire      rxBusy = (rxState_reg != RX_IDLE);

  wire [3:0] rxBits = (char8 ? 4'h8 : 4'h7) + {3'h0, parOn};
  wire [7:0] rxData = char8 ? (parOn ? rxShift_reg[7:0] : rxShift_reg[8:1])
                            : {1'b0, (parOn ? rxShift_reg[8:2]
                                            : rxShift_reg[8:2])};
  wire [7:0] rxData7 = parOn ? {1'b0, rxShift_reg[7:1]}
                             : {1'b0, rxShift_reg[8:2]};
  wire [7:0] rxWord  = char8 ? rxData : rxData7;
  // Parity over all received data and parity bits
  wire       parOnes = oddOnes(char8 ? rxShift_reg[8:0]
                                     : {1'b0, rxShift_reg[8:1]});
  wire       parErr  = (parMode == `ASU_PAR_EVEN) ? parOnes :
                       (parMode == `ASU_PAR_ODD)  ? ~parOnes :
                       1'b0;
  wire       stopTick = (rxState_reg == RX_DATA) && halfTick_reg
                        && rxPhase_reg && (rxCnt_reg == rxBits);
  wire [2:0] newErr   = {parErr, ~rxLine, rxUnread_reg};

  always @* begin
    rxState_next = rxState_reg;
    rxRestart    = 1'b0;
    case (rxState_reg)
      RX_IDLE:
        if (!rxLine) begin
          rxState_next = RX_START;
          rxRestart    = 1'b1;
        end
      RX_START:
        if (halfTick_reg) begin
          rxState_next = rxLine ? RX_IDLE : RX_DATA;
          rxRestart    = !rxLine;
        end
      RX_DATA:
        if (stopTick)
          rxState_next = RX_IDLE;
      default:
        rxState_next = RX_IDLE;
    endcase
    if (!rxEn) begin
      rxState_next = RX_IDLE;
      rxRestart    = 1'b0;
    end
    rxDoneIrq = rxEn && stopTick && ((newErr == 3'h0)
                || !mode_reg[`ASU_MODE_ERRIRQ]);
    rxErrIrq  = rxEn && stopTick && (newErr != 3'h0);
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxState_reg  <= RX_IDLE;
      rxCnt_reg    <= 4'h0;
      rxPhase_reg  <= 1'b0;
      rxShift_reg  <= 9'h000;
      rxBuf_reg    <= 8'h00;
      errStat_reg  <= 3'h0;
      rxUnread_reg <= 1'b0;
    end else begin
      rxState_reg <= rxState_next;
      if (rxRestart) begin
        rxCnt_reg   <= 4'h0;
        rxPhase_reg <= 1'b0;
      end else if (rxState_reg == RX_DATA && halfTick_reg) begin
        rxPhase_reg <= ~rxPhase_reg;
        // Sample at bit centre, LSB first into the top
        if (rxPhase_reg && rxCnt_reg != rxBits) begin
          rxShift_reg <= {rxLine, rxShift_reg[8:1]};
          rxCnt_reg   <= rxCnt_reg + 4'h1;
        end
      end
      // Frame end while enabled: buffer and status update together
      if (rxEn && stopTick) begin
        rxBuf_reg    <= rxWord;
        errStat_reg  <= newErr;
        rxUnread_reg <= 1'b1;
      end else if (rdBuf) begin
        errStat_reg  <= 3'h0;
        rxUnread_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt request outputs
  // --------------------------------------------------------------------------
  assign txCompleteIrq = txDoneIrq;
  assign rxCompleteIrq = rxDoneIrq;
  assign rxErrorIrq    = rxErrIrq;

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  // Mode writes act at once; a rewrite mid-frame is not guarded here
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg   <= `ASU_RST_MODE;
      baud_reg   <= `ASU_RST_BAUD;
      pinSel_reg <= `ASU_RST_PINSEL;
    end else if (regWrStb) begin
      if (wrMode)
        mode_reg <= regWrData;
      if (regAddr == `ASU_OFF_BAUD)
        baud_reg <= regWrData;
      if (regAddr == `ASU_OFF_PINSEL)
        pinSel_reg <= regWrData & 8'h30;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      case (regAddr)
        `ASU_OFF_RXBUF:   regRdData <= rxBuf_reg;
        `ASU_OFF_MODE:    regRdData <= mode_reg;
        `ASU_OFF_ERRSTAT: regRdData <= {5'h00, errStat_reg};
        `ASU_OFF_BAUD:    regRdData <= baud_reg;
        `ASU_OFF_PINSEL:  regRdData <= pinSel_reg;
        `ASU_OFF_FLAGS:   regRdData <= {5'h00, rxBusy, txBusy_reg,
                                        txDoneFlag_reg};
        default:          regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // asu_uart_channel

//--- asu_uart_channel_props.sv
// Port assertions for the serial channel
`timescale 1ns/1ps
module asu_uart_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic serialOutPrimary,
  input wire logic serialOutAlternate,
  input wire logic txCompleteIrq,
  input wire logic rxCompleteIrq,
  input wire logic rxErrorIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // --------------------------------------------------------------
  // Event pulses are single and followed by at least eight low cycles
  // --------------------------------------------------------------
  a_txirq_gap: assert property (
    txCompleteIrq |=> !txCompleteIrq [*8]) else $error("tx pulse repeat");
  a_rxirq_gap: assert property (
    rxCompleteIrq |=> !rxCompleteIrq [*8]) else $error("rx pulse repeat");
  a_errirq_gap: assert property (
    rxErrorIrq |=> !rxErrorIrq [*8]) else $error("error pulse repeat");
  // --------------------------------------------------------------
  // Line shape: stop high before completion, start bit long
  // --------------------------------------------------------------
  a_stop_prim: assert property (
    txCompleteIrq |-> serialOutPrimary && $past(serialOutPrimary, 8))
    else $error("primary not high at stop");
  a_stop_alt: assert property (
    txCompleteIrq |-> serialOutAlternate && $past(serialOutAlternate, 8))
    else $error("alternate not high at stop");
  a_one_output: assert property (
    serialOutPrimary || serialOutAlternate) else $error("both outputs low");
  a_start_prim: assert property (
    $fell(serialOutPrimary) |=> !serialOutPrimary [*7])
    else $error("short primary start bit");
  a_start_alt: assert property (
    $fell(serialOutAlternate) |=> !serialOutAlternate [*7])
    else $error("short alternate start bit");
  c_tx_done: cover property (txCompleteIrq);
  c_rx_done: cover property (rxCompleteIrq);
  c_rx_err: cover property (rxErrorIrq && !rxCompleteIrq);
endmodule // asu_uart_props

bind asu_uart_channel asu_uart_props u_asu_uart_props (
  .clk(clk), .nrst(nrst), .serialOutPrimary(serialOutPrimary),
  .serialOutAlternate(serialOutAlternate), .txCompleteIrq(txCompleteIrq),
  .rxCompleteIrq(rxCompleteIrq), .rxErrorIrq(rxErrorIrq));

//--- asu_remote_uart.sv
// Remote serial transceiver model
`timescale 1ns/1ps
module asu_remote_uart (
  input  wire logic clk,
  input  wire logic txLine,
  output logic      rxLine
);
  int bitLen = 32;
  initial rxLine = 1'b1;
  // Bit 0 of the frame goes first, line idles high afterwards
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) rxLine <= f[i];
      repeat (bitLen - 1) @(posedge clk);
    end
    @(posedge clk) rxLine <= 1'b1;
  endtask
  // Samples mid-bit, returns at the middle of the last bit
  task automatic grab(output logic [11:0] f, input int n);
    int t;
    f = 12'hFFF;
    // Falling edges: the registered line has settled there
    for (t = 0; t < 4000 && txLine !== 1'b0; t++) @(negedge clk);
    repeat (bitLen / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = txLine;
      if (i < n - 1) repeat (bitLen) @(negedge clk);
    end
  endtask
endmodule // asu_remote_uart

//--- asu_uart_channel_tb.sv
// Self-checking bench for the serial channel
`timescale 1ns/1ps
module asu_uart_channel_tb;
  logic        clk = 1'b0, nrst = 1'b0, extClk = 1'b0, altSel = 1'b0;
  logic        regWrStb = 1'b0, regRdStb = 1'b0;
  logic [2:0]  regAddr = 3'h0;
  logic [7:0]  regWrData = 8'h00, rd;
  logic [11:0] got;
  wire  [7:0]  regRdData;
  wire         outP, outA, txIrq, rxIrq, errIrq, line;
  int          bad_count = 0, n_tests = 0, txN = 0, rxN = 0, erN = 0, r0, e0;
  logic [7:0]  txm [5] = '{8'h88, 8'h98, 8'hA8, 8'hB8, 8'hB4};
  logic [55:0] rxTab [8] = '{56'h7878A3000A3010, 56'h7878A3200A3411,
    56'h6868A3000A3010, 56'h6868A3200A3411, 56'h5858A3200A3010,
    56'h4848A3200A3211, 56'h4048C300043010, 56'h7A78A3200A3401};

  always #4 clk = ~clk;
  always #16 extClk = ~extClk;
  always @(negedge clk) begin
    txN += (txIrq === 1'b1);
    rxN += (rxIrq === 1'b1);
    erN += (errIrq === 1'b1);
  end

  asu_uart_channel u_asu_uart_channel (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .serialInPrimary(altSel ? 1'b1 : line),
    .serialInAlternate(altSel ? line : 1'b1),
    .externalBaudClockPin(extClk), .serialOutPrimary(outP),
    .serialOutAlternate(outA), .txCompleteIrq(txIrq),
    .rxCompleteIrq(rxIrq), .rxErrorIrq(errIrq));
  asu_remote_uart u_asu_remote_uart (
    .clk(clk), .txLine(altSel ? outA : outP), .rxLine(line));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [11:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rdr(input logic [2:0] a);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 rd = regRdData;
  endtask
  function automatic int nb(input logic [7:0] m);
    return (m[3] ? 10 : 9) + int'(m[5:4] != 2'h0) + int'(m[2]);
  endfunction
  function automatic logic [11:0] mkFrame(input logic [7:0] m, d);
    logic [11:0] f;
    logic p;
    int w;
    f = 12'hFFE;
    p = 1'b0;
    w = m[3] ? 8 : 7;
    for (int i = 0; i < w; i++) begin
      f[i + 1] = d[i];
      p ^= d[i];
    end
    case (m[5:4])
      2'h1: f[w + 1] = 1'b0;
      2'h2: f[w + 1] = ~p;
      2'h3: f[w + 1] = p;
      default: ;
    endcase
    return f;
  endfunction
  task automatic txCase(input logic [7:0] m, d);
    int t;
    wr(3'h1, m);
    wr(3'h0, d);
    r0 = txN;
    u_asu_remote_uart.grab(got, nb(m));
    chk("tx frame", mkFrame(m, d), got);
    for (t = 0; t < 200 && txN == r0; t++) @(negedge clk);
    chk("tx irq", 12'(r0 + 1), 12'(txN));
    rdr(3'h5);
    chk("tx flag", 12'h001, 12'(rd & 8'h03));
    $display("test tx %h %h done", m, d);
  endtask
  task automatic rxCase(input logic [55:0] c);
    r0 = rxN;
    e0 = erN;
    wr(3'h1, c[55:48]);
    u_asu_remote_uart.send(mkFrame(c[47:40], c[39:32]) ^ c[31:20],
      nb(c[47:40]));
    repeat (4) @(negedge clk);
    chk("rx irq", 12'(c[7:4]), 12'(rxN - r0));
    chk("err irq", 12'(c[3:0]), 12'(erN - e0));
    rdr(3'h2);
    chk("status", 12'(c[11:8]), 12'(rd));
    rdr(3'h0);
    chk("rx data", 12'(c[19:12]), 12'(rd));
    rdr(3'h2);
    chk("status clear", 12'h000, 12'(rd));
    $display("test rx %h done", c[55:48]);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rdr(3'(a));
      chk("reset value", 12'h000, 12'(rd));
    end
    $display("test reset values done");
    wr(3'h3, 8'h05);
    rdr(3'h3);
    chk("baud", 12'h005, 12'(rd));
    foreach (txm[i]) txCase(txm[i], 8'hB5);
    foreach (rxTab[i]) rxCase(rxTab[i]);
    wr(3'h1, 8'h48);
    repeat (2) u_asu_remote_uart.send(mkFrame(8'h48, 8'h5A), 10);
    repeat (4) @(negedge clk);
    rdr(3'h2);
    chk("overrun", 12'h001, 12'(rd));
    rdr(3'h0);
    chk("overrun data", 12'h05A, 12'(rd));
    r0 = rxN;
    e0 = erN;
    fork
      u_asu_remote_uart.send(mkFrame(8'h48, 8'h0F), 10);
      begin
        repeat (100) @(posedge clk);
        wr(3'h1, 8'h00);
      end
    join
    chk("abort irqs", 12'(r0 + e0), 12'(rxN + erN));
    rdr(3'h0);
    chk("abort data", 12'h05A, 12'(rd));
    $display("test overrun and abort done");
    r0 = txN;
    wr(3'h1, 8'h88);
    wr(3'h0, 8'h00);
    repeat (100) @(posedge clk);
    wr(3'h1, 8'h08);
    wr(3'h0, 8'hFF);
    repeat (4) @(negedge clk);
    chk("abort line", 12'h001, 12'(outP));
    chk("abort tx irq", 12'(r0), 12'(txN));
    rdr(3'h5);
    chk("abort flags", 12'h000, 12'(rd & 8'h03));
    $display("test tx abort done");
    wr(3'h4, 8'h30);
    altSel <= 1'b1;
    txCase(8'h88, 8'h3C);
    rxCase(rxTab[0]);
    wr(3'h1, 8'h00);
    wr(3'h4, 8'h00);
    altSel <= 1'b0;
    u_asu_remote_uart.bitLen = 128;
    txCase(8'h89, 8'h96);
    wr(3'h3, 8'h16);
    u_asu_remote_uart.bitLen = 68;
    txCase(8'h88, 8'h96);
    complete_run;
  end
endmodule // asu_uart_channel_tb
